/* File: pkg/nad_defines.vh */
`ifndef NAD_DEFINES_VH
`define NAD_DEFINES_VH

// ==========================================================
// Opcode fields of the 10-bit program word
// ==========================================================
// Word is {op_hi5, op_lo5}; op_hi5[0] picks low (1) or high (0) side
`define NAD_WORD_W 10
`define NAD_LO_TBL 5'h10
`define NAD_LO_IMM 5'h11
`define NAD_LO_ACC 5'h13
`define NAD_LO_PORT 2'h3
`define NAD_CLS_AND 4'hD
`define NAD_CLS_OR 4'hE
`define NAD_CLS_XOR 4'hA
`define NAD_CLS_IN 4'hF
`define NAD_CLS_OUT 4'h2
`define NAD_HI_OUTI 5'h06
`define NAD_HI_INC 5'h14
`define NAD_HI_ROL 5'h1C
`define NAD_HI_ROTRST 5'h1E

// ==========================================================
// Arithmetic unit operations
// ==========================================================
`define NAD_ALU_LOAD 3'h0
`define NAD_ALU_AND 3'h1
`define NAD_ALU_OR 3'h2
`define NAD_ALU_XOR 3'h3
`define NAD_ALU_INC 3'h4
`define NAD_ALU_ROL 3'h5

// ==========================================================
// Register map (byte addresses)
// ==========================================================
`define NAD_REG_CTRL 8'h00
`define NAD_REG_STATUS 8'h04
`define NAD_REG_TPAGE 8'h08
`define NAD_REG_PORTS 8'h0C
`define NAD_BANK_LOW 2'h1
`define NAD_BANK_HIGH 2'h2
`define NAD_CTRL_EN_BIT 0
`define NAD_STAT_CARRY_BIT 4

// ==========================================================
// Reset values
// ==========================================================
`define NAD_CTRL_RST 1'h0
`define NAD_ACC_RST 4'h0
`define NAD_PORT_RST 8'hFF
`define NAD_TPAGE_RST 4'h0
`define NAD_BANK_RST 4'h0

`endif

/* File: hw/nad_alu.v */
`timescale 1ns/1ps
`include "nad_defines.vh"

module nad_alu
(
	input wire [2:0] op_i,
	input wire [3:0] acc_i,
	input wire [3:0] opnd_i,
	output reg [3:0] acc_o,
	output reg carry_o
);

	always @*
	begin
		acc_o = acc_i;
		carry_o = 1'b0;
		case (op_i)
			`NAD_ALU_LOAD:
			begin
				acc_o = opnd_i;
				carry_o = 1'b0;
			end
			// RULE3 and carry
			`NAD_ALU_AND:
			begin
				acc_o = acc_i & opnd_i;
				carry_o = acc_i[3] & opnd_i[3];
			end
			// RULE4 or clears carry
			`NAD_ALU_OR:
			begin
				acc_o = acc_i | opnd_i;
				carry_o = 1'b0;
			end
			// RULE5 xor carry
			`NAD_ALU_XOR:
			begin
				acc_o = acc_i ^ opnd_i;
				carry_o = acc_i[3] & opnd_i[3];
			end
			// RULE8 RULE19 wrap sets carry
			`NAD_ALU_INC:
			begin
				acc_o = acc_i + 4'h1;
				carry_o = (acc_i == 4'hF);
			end
			// RULE9 rotate left
			`NAD_ALU_ROL:
			begin
				acc_o = {acc_i[2:0], acc_i[3]};
				carry_o = acc_i[3];
			end
			default:
			begin
				acc_o = acc_i;
				carry_o = 1'b0;
			end
		endcase
	end

endmodule // nad_alu

/* File: hw/nad_top.v */
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "nad_defines.vh"

// Contract
// RULE1 - program words are 10 bits wide
// RULE2 - decode 16-bit code minus both 111 fields
// RULE3 - and with register, carry from bit 3
// RULE4 - or with register clears carry
// RULE5 - xor with register, carry from bit 3
// RULE6 - table forms use ROM high or low nibble
// RULE7 - immediate forms take nibble from second word
// RULE8 - increment sets carry on wrap to zero
// RULE9 - rotate left, old bit 3 to carry
// RULE10 - rotate-or-reset resets when accumulator zero
// RULE11 - port read loads nibble, clears carry
// RULE12 - port write stores accumulator to nibble
// RULE13 - and with port nibble, carry from bit 3
// RULE14 - or with port nibble clears carry
// RULE15 - xor with port nibble, carry from bit 3
// RULE16 - immediate byte written to whole port pair
// RULE17 - only port pairs 0, 1, 3, 4
// RULE18 - sixteen low and sixteen high data registers
// RULE19 - increment clears carry when nonzero
// RULE20 - each instruction is one instruction cycle; two-word and table forms take two cycles here
module nad_top
#(
	parameter PAGE_W = 4
)
(
	input wire clk_i,
	input wire rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire instr_valid_i,
	input wire [`NAD_WORD_W-1:0] instr_i,
	output wire instr_ready_o,
	output wire [PAGE_W+7:0] rom_addr_o,
	input wire [`NAD_WORD_W-1:0] tbl_data_i,
	output wire [3:0] acc_o,
	output wire carry_bit_o,
	output wire [39:0] port_pair_o,
	output wire reset_req_o
);

	// ==========================================================
	// Decode helpers
	// ==========================================================
	// RULE17 legal pair index
	function port_ok;
		input [2:0] idx;
		begin
			port_ok = (idx == 3'd0) | (idx == 3'd1) | (idx == 3'd3) |
				(idx == 3'd4);
		end
	endfunction

	// RULE7 RULE16 two-word forms
	function needs_opnd;
		input [9:0] w;
		begin
			needs_opnd = ((w[4:0] == `NAD_LO_IMM) &&
				((w[9:6] == `NAD_CLS_AND) || (w[9:6] == `NAD_CLS_OR) ||
				(w[9:6] == `NAD_CLS_XOR)) && w[5]) ||
				((w[9:5] == `NAD_HI_OUTI) && (w[4:3] == `NAD_LO_PORT));
		end
	endfunction

	function [2:0] cls_op;
		input [3:0] cls;
		begin
			case (cls)
				`NAD_CLS_AND: cls_op = `NAD_ALU_AND;
				`NAD_CLS_OR: cls_op = `NAD_ALU_OR;
				`NAD_CLS_XOR: cls_op = `NAD_ALU_XOR;
				default: cls_op = `NAD_ALU_LOAD;
			endcase
		end
	endfunction

	function logic_cls;
		input [3:0] cls;
		begin
			logic_cls = (cls == `NAD_CLS_AND) || (cls == `NAD_CLS_OR) ||
				(cls == `NAD_CLS_XOR);
		end
	endfunction

	// ==========================================================
	// State
	// ==========================================================
	localparam S_FETCH = 2'd0;
	localparam S_OPND = 2'd1;
	localparam S_TBL = 2'd2;

	reg [1:0] state_r, state_nxt;
	// RULE1 ten-bit held word
	reg [9:0] op_r, op_nxt;
	reg [3:0] acc_r, acc_nxt;
	reg carry_r, carry_nxt;
	reg ready_r;
	reg rst_req_r, rst_req_nxt;
	reg en_r;
	reg [PAGE_W-1:0] table_page_reg;
	reg [PAGE_W+7:0] rom_addr_r;
	reg [3:0] low_bank_reg [0:15];
	reg [3:0] high_bank_reg [0:15];
	reg pready_r;
	reg pslverr_r;
	reg [31:0] prdata_r;

	wire take_w = instr_valid_i & ready_r;
	wire [9:0] cur_w = (state_r == S_FETCH) ? instr_i : op_r;
	wire [4:0] hi5 = cur_w[9:5];
	wire [4:0] lo5 = cur_w[4:0];
	wire [3:0] cls = hi5[4:1];
	wire sel_lo = hi5[0];
	wire [2:0] pidx = lo5[2:0];
	wire [39:0] port_w;
	wire [7:0] pair_w = port_w[pidx*8 +: 8];

	// ==========================================================
	// Decode and execute
	// ==========================================================
	reg exec;
	reg [2:0] alu_op;
	reg [3:0] opnd;
	reg acc_wr;
	reg pwr_lo, pwr_hi;
	reg [7:0] pwr_data;
	wire [3:0] alu_acc;
	wire alu_carry;

	nad_alu u_alu
	(
		.op_i(alu_op),
		.acc_i(acc_r),
		.opnd_i(opnd),
		.acc_o(alu_acc),
		.carry_o(alu_carry)
	);

	always @*
	begin
		state_nxt = state_r;
		op_nxt = op_r;
		exec = 1'b0;
		case (state_r)
			S_FETCH:
			begin
				if (take_w)
				begin
					op_nxt = instr_i;
					if (needs_opnd(instr_i))
						state_nxt = S_OPND;
					else if (instr_i[4:0] == `NAD_LO_TBL)
						state_nxt = S_TBL;
					else
						exec = 1'b1;
				end
			end
			// RULE20 second word ends it
			S_OPND:
			begin
				if (take_w)
				begin
					exec = 1'b1;
					state_nxt = S_FETCH;
				end
			end
			S_TBL:
			begin
				exec = 1'b1;
				state_nxt = S_FETCH;
			end
			default: state_nxt = S_FETCH;
		endcase
	end

	always @*
	begin
		alu_op = `NAD_ALU_LOAD;
		opnd = 4'h0;
		acc_wr = 1'b0;
		pwr_lo = 1'b0;
		pwr_hi = 1'b0;
		pwr_data = 8'h00;
		rst_req_nxt = 1'b0;
		if (exec)
		begin
			alu_op = cls_op(cls);
			// RULE2 match stripped word
			if (lo5[4] == 1'b0)
			begin
				// RULE18 bank select
				opnd = sel_lo ? low_bank_reg[lo5[3:0]] :
					high_bank_reg[lo5[3:0]];
				acc_wr = logic_cls(cls);
			end
			else if (lo5 == `NAD_LO_TBL)
			begin
				// RULE6 ROM nibble
				opnd = sel_lo ? tbl_data_i[3:0] : tbl_data_i[7:4];
				acc_wr = logic_cls(cls);
			end
			else if (lo5 == `NAD_LO_IMM)
			begin
				// RULE7 immediate nibble
				opnd = instr_i[3:0];
				acc_wr = logic_cls(cls);
			end
			else if (lo5 == `NAD_LO_ACC)
			begin
				case (hi5)
					`NAD_HI_INC:
					begin
						alu_op = `NAD_ALU_INC;
						acc_wr = 1'b1;
					end
					`NAD_HI_ROL:
					begin
						alu_op = `NAD_ALU_ROL;
						acc_wr = 1'b1;
					end
					// RULE10 zero resets
					`NAD_HI_ROTRST:
					begin
						alu_op = `NAD_ALU_ROL;
						acc_wr = (acc_r != 4'h0);
						rst_req_nxt = (acc_r == 4'h0);
					end
					default: acc_wr = 1'b0;
				endcase
			end
			else if ((lo5[4:3] == `NAD_LO_PORT) && port_ok(pidx))
			begin
				// RULE11 RULE13 RULE14 RULE15 port nibble
				opnd = sel_lo ? pair_w[3:0] : pair_w[7:4];
				acc_wr = logic_cls(cls) || (cls == `NAD_CLS_IN);
				// RULE12 store accumulator
				if (cls == `NAD_CLS_OUT)
				begin
					pwr_lo = sel_lo;
					pwr_hi = ~sel_lo;
					pwr_data = {acc_r, acc_r};
				end
				// RULE16 whole pair
				if (hi5 == `NAD_HI_OUTI)
				begin
					pwr_lo = 1'b1;
					pwr_hi = 1'b1;
					pwr_data = instr_i[7:0];
				end
			end
		end
		acc_nxt = acc_wr ? alu_acc : acc_r;
		carry_nxt = acc_wr ? alu_carry : carry_r;
	end

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r <= S_FETCH;
			op_r <= 10'h000;
			acc_r <= `NAD_ACC_RST;
			carry_r <= 1'b0;
			ready_r <= 1'b0;
			rst_req_r <= 1'b0;
			rom_addr_r <= {(PAGE_W+8){1'b0}};
		end
		else
		begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			acc_r <= acc_nxt;
			carry_r <= carry_nxt;
			// Table wait holds off the next word one cycle
			ready_r <= en_r & (state_nxt != S_TBL);
			rst_req_r <= rst_req_nxt;
			rom_addr_r <= {table_page_reg, high_bank_reg[0],
				low_bank_reg[0]};
		end
	end

	// ==========================================================
	// Port register pairs
	// ==========================================================
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1)
		begin : g_port
			reg [7:0] pair_r;
			always @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
					pair_r <= `NAD_PORT_RST;
				else if (pidx == g)
				begin
					if (pwr_hi)
						pair_r[7:4] <= pwr_data[7:4];
					if (pwr_lo)
						pair_r[3:0] <= pwr_data[3:0];
				end
			end
			assign port_w[g*8 +: 8] = pair_r;
		end
	endgenerate

	// ==========================================================
	// APB slave
	// ==========================================================
	wire apb_acc = psel_i & penable_i;
	wire apb_wr = apb_acc & pready_r & pwrite_i;
	wire bank_lo = (paddr_i[7:6] == `NAD_BANK_LOW);
	wire bank_hi = (paddr_i[7:6] == `NAD_BANK_HIGH);
	wire [3:0] bidx = paddr_i[5:2];
	reg [31:0] rd_val;
	reg rd_err;

	always @*
	begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr_i[1:0] != 2'b00)
			rd_err = 1'b1;
		else if (bank_lo)
			rd_val = {28'h0000000, low_bank_reg[bidx]};
		else if (bank_hi)
			rd_val = {28'h0000000, high_bank_reg[bidx]};
		else
		begin
			case (paddr_i)
				`NAD_REG_CTRL: rd_val = {31'h00000000, en_r};
				`NAD_REG_STATUS:
				begin
					rd_val = {25'h0000000, state_r, carry_r, acc_r};
					rd_err = pwrite_i;
				end
				`NAD_REG_TPAGE:
					rd_val = {{(32-PAGE_W){1'b0}}, table_page_reg};
				`NAD_REG_PORTS:
				begin
					rd_val = {port_w[39:24], port_w[15:0]};
					rd_err = pwrite_i;
				end
				default: rd_err = 1'b1;
			endcase
		end
	end

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			en_r <= `NAD_CTRL_RST;
			table_page_reg <= `NAD_TPAGE_RST;
		end
		else
		begin
			// One wait state so answers come from flops
			pready_r <= apb_acc & ~pready_r;
			pslverr_r <= apb_acc & ~pready_r & rd_err;
			prdata_r <= (apb_acc & ~pready_r & ~pwrite_i & ~rd_err) ?
				rd_val : 32'h0000_0000;
			if (apb_wr && !rd_err && paddr_i == `NAD_REG_CTRL)
				en_r <= pwdata_i[`NAD_CTRL_EN_BIT];
			if (apb_wr && !rd_err && paddr_i == `NAD_REG_TPAGE)
				table_page_reg <= pwdata_i[PAGE_W-1:0];
		end
	end

	integer i;
	// RULE18 data register banks
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (i = 0; i < 16; i = i + 1)
			begin
				low_bank_reg[i] <= `NAD_BANK_RST;
				high_bank_reg[i] <= `NAD_BANK_RST;
			end
		end
		else if (apb_wr && !rd_err)
		begin
			if (bank_lo)
				low_bank_reg[bidx] <= pwdata_i[3:0];
			if (bank_hi)
				high_bank_reg[bidx] <= pwdata_i[3:0];
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign instr_ready_o = ready_r;
	assign rom_addr_o = rom_addr_r;
	assign acc_o = acc_r;
	assign carry_bit_o = carry_r;
	assign port_pair_o = port_w;
	assign reset_req_o = rst_req_r;

endmodule // nad_top

/* File: bench/nad_top_sva.sv */
`timescale 1ns/1ps
// ====================
// Accumulator and port checker
module nad_chk
(
	input wire clk_i,
	input wire rst_i,
	input wire pready_o,
	input wire instr_valid_i,
	input wire [9:0] instr_i,
	input wire instr_ready_o,
	input wire [3:0] acc_o,
	input wire carry_bit_o,
	input wire [39:0] port_pair_o,
	input wire reset_req_o
);
reg [3:0] pa;
wire tk = instr_valid_i && instr_ready_o;
// Accumulator as it stood before the last edge
always @(posedge clk_i)
begin
	pa <= acc_o;
end
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
ready_pulse_a: assert property (pready_o |=> !pready_o)
	else $error("pready longer than one cycle");
inc_wrap_a: assert property (
	tk && instr_i == {5'h14, 5'h13} |=> acc_o == pa + 4'h1
	&& carry_bit_o == (pa == 4'hF)) else $error("increment wrong");
rotate_a: assert property (
	tk && instr_i == {5'h1C, 5'h13} |=> acc_o == {pa[2:0], pa[3]}
	&& carry_bit_o == pa[3]) else $error("rotate wrong");
rotrst_zero_a: assert property (
	tk && instr_i == {5'h1E, 5'h13} && acc_o == 4'h0
	|=> reset_req_o) else $error("no reset request");
rotrst_rot_a: assert property (
	tk && instr_i == {5'h1E, 5'h13} && acc_o != 4'h0
	|=> !reset_req_o && acc_o == {pa[2:0], pa[3]})
	else $error("rotate or reset wrong");
or_clear_a: assert property (
	tk && instr_i[9:6] == 4'hE && !instr_i[4] |=> !carry_bit_o)
	else $error("or left carry set");
bad_pair_a: assert property (
	tk && instr_i[9:6] == 4'h2 && instr_i[4:3] == 2'b11
	&& (instr_i[2:0] == 3'h2 || instr_i[2:0] > 3'h4)
	|=> $stable(port_pair_o)) else $error("bad pair written");
out_low_a: assert property (
	tk && instr_i == {5'h05, 5'h18} |=> port_pair_o[3:0] == pa)
	else $error("port write wrong");
tbl_slot_a: assert property (
	tk && instr_i[4:0] == 5'h10 && instr_i[9:6] inside {4'hA, 4'hD, 4'hE}
	|=> !instr_ready_o ##1 instr_ready_o) else $error("table slot wrong");
endmodule // nad_chk
bind nad_top nad_chk chk (.*);

/* File: bench/nad_prog_mem.sv */
`timescale 1ns/1ps
// ====================
// Program memory model
module nad_prog_mem
(
	input wire clk_i,
	input wire instr_ready_o,
	input wire [11:0] rom_addr_o,
	output logic instr_valid_i,
	output logic [9:0] instr_i,
	output wire [9:0] tbl_data_i
);
assign tbl_data_i = rom_addr_o[9:0] ^ 10'h0C6;
initial
begin
	instr_valid_i = 1'b0;
	instr_i = 10'h3A5;
end
task automatic send(input logic [9:0] w, output logic ok);
	int n;
	instr_valid_i <= 1'b1;
	instr_i <= w;
	ok = 1'b0;
	for (n = 0; n < 20 && !ok; n++)
	begin
		@(posedge clk_i);
		ok = instr_ready_o === 1'b1;
	end
endtask
// Idle bus flips, so a stale word is never mistaken
task idle;
	instr_valid_i <= 1'b0;
	instr_i <= ~instr_i;
endtask
endmodule // nad_prog_mem

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`define CK(a, b) check_count++; \
	if ((a) !== (b)) \
	begin \
		err_count++; \
		$display("FAIL t=%0t got %0h exp %0h", $time, a, b); \
	end
// ====================
// Bench top
module testbench;
typedef struct packed {logic [9:0] w; logic [9:0] d; logic [3:0] a; logic c;}
	nad_row_t;
logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
logic pwrite_i = 1'b0, pready_o, pslverr_o, instr_valid_i, instr_ready_o;
logic carry_bit_o, reset_req_o, er, ok;
logic [7:0] paddr_i = 8'h00;
logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
logic [9:0] instr_i, tbl_data_i;
logic [11:0] rom_addr_o;
logic [3:0] acc_o;
logic [39:0] port_pair_o;
int err_count = 0, check_count = 0, i;
// Rows chain: each starts from the previous accumulator
nad_row_t rows [23] = '{
	'{{5'h1D, 5'h11}, 10'h00C, 4'hC, 1'b0}, '{{5'h14, 5'h02}, 10'h0, 4'h1, 1'b1},
	'{{5'h14, 5'h13}, 10'h0, 4'h2, 1'b0}, '{{5'h1D, 5'h11}, 10'h00F, 4'hF, 1'b0},
	'{{5'h14, 5'h13}, 10'h0, 4'h0, 1'b1}, '{{5'h1D, 5'h09}, 10'h0, 4'h9, 1'b0},
	'{{5'h1A, 5'h00}, 10'h0, 4'h9, 1'b1}, '{{5'h1C, 5'h13}, 10'h0, 4'h3, 1'b1},
	'{{5'h1C, 5'h10}, 10'h0, 4'h3, 1'b0}, '{{5'h15, 5'h10}, 10'h0, 4'h5, 1'b0},
	'{{5'h1A, 5'h10}, 10'h0, 4'h1, 1'b0}, '{{5'h15, 5'h11}, 10'h008, 4'h9, 1'b0},
	'{{5'h1B, 5'h11}, 10'h00C, 4'h8, 1'b1}, '{{5'h1E, 5'h13}, 10'h0, 4'h1, 1'b1},
	'{{5'h05, 5'h18}, 10'h0, 4'h1, 1'b1}, '{{5'h04, 5'h1B}, 10'h0, 4'h1, 1'b1},
	'{{5'h06, 5'h1C}, 10'h05A, 4'h1, 1'b1}, '{{5'h1E, 5'h1C}, 10'h0, 4'h5, 1'b0},
	'{{5'h15, 5'h1C}, 10'h0, 4'hF, 1'b0}, '{{5'h1B, 5'h1B}, 10'h0, 4'hF, 1'b1},
	'{{5'h1D, 5'h19}, 10'h0, 4'hF, 1'b0}, '{{5'h05, 5'h1A}, 10'h0, 4'hF, 1'b0},
	'{{5'h15, 5'h11}, 10'h00F, 4'h0, 1'b1}};
always #2 clk_i = ~clk_i;
nad_top dut (.*);
nad_prog_mem pm (.*);
task finish_test;
	if (err_count == 0 && check_count > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
task hang;
	err_count++;
	finish_test;
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	int n;
	@(posedge clk_i);
	psel_i <= 1'b1;
	pwrite_i <= w;
	paddr_i <= a;
	pwdata_i <= d;
	@(posedge clk_i);
	penable_i <= 1'b1;
	for (n = 0; n < 20; n++)
	begin
		@(posedge clk_i);
		if (pready_o === 1'b1)
			break;
	end
	rd = prdata_o;
	er = pslverr_o;
	psel_i <= 1'b0;
	penable_i <= 1'b0;
	if (n == 20)
		hang;
endtask
task run(input logic [9:0] w, input logic [9:0] d);
	int n;
	@(posedge clk_i);
	pm.send(w, ok);
	if (ok && (w[4:0] == 5'h11 || w[9:5] == 5'h06))
		pm.send(d, ok);
	pm.idle;
	for (n = 0; n < 9; n++)
	begin
		@(negedge clk_i);
		if (instr_ready_o === 1'b1)
			break;
	end
	if (!ok || n == 9)
		hang;
endtask
initial
begin
	repeat (5) @(posedge clk_i);
	rst_i <= 1'b0;
	apb(1'b1, 8'h00, 32'h1);
	for (i = 0; i < 16; i++)
	begin
		apb(1'b1, 8'h40 + 8'(4 * i), 32'(i));
		apb(1'b1, 8'h80 + 8'(4 * i), 32'(15 - i));
	end
	apb(1'b1, 8'h08, 32'h5);
	foreach (rows[k])
	begin
		run(rows[k].w, rows[k].d);
		`CK(acc_o, rows[k].a)
		`CK(carry_bit_o, rows[k].c)
	end
	`CK(rom_addr_o, 12'h5F0)
	`CK(port_pair_o, 40'h5A1FFFFFF1)
	run({5'h1E, 5'h13}, 10'h000);
	`CK(reset_req_o, 1'b1)
	apb(1'b0, 8'h4C, 32'h0);
	`CK(rd[3:0], 4'h3)
	apb(1'b0, 8'h20, 32'h0);
	`CK(er, 1'b1)
	apb(1'b1, 8'h04, 32'h0);
	`CK(er, 1'b1)
	@(posedge clk_i);
	rst_i <= 1'b1;
	@(posedge clk_i);
	rst_i <= 1'b0;
	@(negedge clk_i);
	`CK(({instr_ready_o, carry_bit_o, acc_o}), 6'h00)
	`CK(port_pair_o, {5{8'hFF}})
	finish_test;
end
endmodule // testbench
